/* inc/fisr_map.vh */
// register offsets, field positions, reset values and timing counts for the flash control block
`ifndef FISR_MAP_VH
`define FISR_MAP_VH
`define FISR_OFF_STATUS 12'h000
`define FISR_OFF_CONFIG 12'h004
`define FISR_OFF_FAULT_STATUS 12'h008
`define FISR_OFF_FAULT_CONFIG 12'h00C
`define FISR_OFF_SECURITY 12'h010
`define FISR_OFF_PROT_PROG 12'h014
`define FISR_OFF_PROT_DATA 12'h018
`define FISR_OFF_OPTION 12'h01C
`define FISR_OFF_CMD_INDEX 12'h020
`define FISR_OFF_CMD_WORD 12'h024
`define FISR_OFF_KEY_LO 12'h028
`define FISR_OFF_KEY_HI 12'h02C
`define FISR_OFF_CONTROL 12'h030
`define FISR_OFF_STATE 12'h034
`define FISR_SEC_BYTE_ADDR 18'h3_FF0F
`define FISR_KEY_BASE_ADDR 18'h3_FF00
`define FISR_PROT_ADDR 18'h3_FF0C
`define FISR_DPROT_ADDR 18'h3_FF0D
`define FISR_OPT_ADDR 18'h3_FF0E
`define FISR_SEC_UNSECURE 2'b10
`define FISR_SEC_DEFAULT 8'h00
`define FISR_PROT_DEFAULT 8'h00
`define FISR_OPT_DEFAULT 8'hFF
`define FISR_KEY_ENABLED 2'b10
`define FISR_KEY_BAD0 16'h0000
`define FISR_KEY_BAD1 16'hFFFF
`define FISR_STAT_CMD_COMPLETE_FLAG_BIT 7
`define FISR_STAT_ACCERR_BIT 5
`define FISR_STAT_MG1_BIT 1
`define FISR_STAT_MG0_BIT 0
`define FISR_HOLD_CYCLES 4'h4
`define FISR_CMD_CYCLES 8'h10
`define FISR_CMD_VERIFY_KEY 8'h0C
`define FISR_CMD_ERASE_VERIFY_ALL 8'h01
`define FISR_CMD_ERASE_ALL 8'h08
`endif

/* src/fisr_ctrl.v */
// flash control block: interrupts, low power, security and reset load sequence
//
// What this block does
// - command irq when complete flag and enable
// - error irq on enabled double or single fault
// - ecc double/single read faults set flags
// - wait mode changes nothing; complete irq wakes
// - stop request waits for running command
// - security register loaded at reset from flash
// - programmed security byte waits for next reset
// - key verify when enabled unsecures on match
// - all-zero and all-one keys are invalid
// - array reads blocked during key verify
// - wrong key locks verify until reset
// - key verify leaves stored settings unchanged
// - erased arrays after reset in special mode mean unsecured
// - commands gated by mode and security
// - reset sequence loads protection, option, security
// - load errors fall back to secured defaults
// - double fault in load sets both status bits
// - complete flag low; early accesses stalled
// - command writes ignored until sequence completes
// - reset aborts any running command
`timescale 1ns/1ps
`include "fisr_map.vh"
module fisr_ctrl (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg flash_rd_req,
   output reg [17:0] flash_rd_addr,
   input wire flash_rd_valid,
   input wire [15:0] flash_rd_data,
   input wire flash_rd_single_fault,
   input wire flash_rd_double_fault,
   input wire flash_array_erased,
   input wire array_read_single_fault,
   input wire array_read_double_fault,
   input wire special_mode,
   input wire stop_req,
   input wire wait_mode,
   output reg stop_ack,
   output reg array_read_block,
   output reg cmd_irq,
   output reg error_irq,
   output reg secured,
   output reg debug_cmds_enabled
);
   localparam ST_HOLD = 3'd0;
   localparam ST_LOAD = 3'd1;
   localparam ST_WAITRD = 3'd2;
   localparam ST_IDLE = 3'd3;
   localparam ST_RUN = 3'd4;
   reg [2:0] state;
   reg [3:0] hold_cnt;
   reg [2:0] load_idx;
   reg [7:0] run_cnt;
   reg cmd_complete_flag;
   reg cmd_complete_irq_en;
   reg double_fault_flag;
   reg double_fault_irq_en;
   reg single_fault_flag;
   reg single_fault_irq_en;
   reg acc_err;
   reg [1:0] verify_fault_status;
   reg [7:0] security_reg;
   reg [7:0] program_array_protect_reg;
   reg [7:0] data_array_protect_reg;
   reg [7:0] option_reg;
   reg [2:0] cmd_index_reg;
   reg [7:0] cmd_code;
   reg [63:0] offered_key;
   reg [63:0] stored_key;
   reg key_locked;
   reg load_err;
   reg erased_seen;
   reg [31:0] rdata;
   wire acc = psel & penable & pready;
   // writes land only at the edge that completes the access
   wire wr = acc & pwrite;
   wire stall = (state == ST_HOLD);
   wire [1:0] key_access_enable_field = security_reg[7:6];
   wire [1:0] security_state_field = security_reg[1:0];
   wire key_cmd = (cmd_code == `FISR_CMD_VERIFY_KEY);
   wire cmd_wr_ok = cmd_complete_flag;
   wire [17:0] load_addr;
   wire launch;
   wire allowed;
   wire key_invalid;
   wire key_match;
   assign load_addr = (load_idx < 3'd4) ? (`FISR_KEY_BASE_ADDR + {14'h0000, load_idx, 1'b0}) :
      (load_idx == 3'd4) ? `FISR_PROT_ADDR : (load_idx == 3'd5) ? `FISR_DPROT_ADDR :
      (load_idx == 3'd6) ? `FISR_OPT_ADDR : `FISR_SEC_BYTE_ADDR;
   // a command launches by writing 1 to the complete flag while it is set
   assign launch = wr & ~stall & (paddr == `FISR_OFF_STATUS) & pwdata[`FISR_STAT_CMD_COMPLETE_FLAG_BIT] & cmd_complete_flag;
   // secured parts outside special mode refuse erase-all and bad key use
   assign allowed = key_cmd ? (key_access_enable_field == `FISR_KEY_ENABLED) & ~key_locked :
      (cmd_code == `FISR_CMD_ERASE_ALL) ? (special_mode | ~secured) : 1'b1;
   genvar gi;
   wire [3:0] word_bad;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_key
         assign word_bad[gi] = (offered_key[gi*16 +: 16] == `FISR_KEY_BAD0) |
            (offered_key[gi*16 +: 16] == `FISR_KEY_BAD1);
      end
   endgenerate
   assign key_invalid = |word_bad;
   assign key_match = ~key_invalid & (offered_key == stored_key);
   always @* begin
      rdata = 32'h0000_0000;
      case (paddr)
         `FISR_OFF_STATUS: rdata = {24'h00_0000, cmd_complete_flag, 1'b0, acc_err, 3'b000, verify_fault_status};
         `FISR_OFF_CONFIG: rdata = {24'h00_0000, cmd_complete_irq_en, 7'h00};
         `FISR_OFF_FAULT_STATUS: rdata = {30'h0000_0000, double_fault_flag, single_fault_flag};
         `FISR_OFF_FAULT_CONFIG: rdata = {30'h0000_0000, double_fault_irq_en, single_fault_irq_en};
         `FISR_OFF_SECURITY: rdata = {24'h00_0000, security_reg};
         `FISR_OFF_PROT_PROG: rdata = {24'h00_0000, program_array_protect_reg};
         `FISR_OFF_PROT_DATA: rdata = {24'h00_0000, data_array_protect_reg};
         `FISR_OFF_OPTION: rdata = {24'h00_0000, option_reg};
         `FISR_OFF_CMD_INDEX: rdata = {29'h0000_0000, cmd_index_reg};
         `FISR_OFF_CMD_WORD: rdata = {24'h00_0000, cmd_code};
         `FISR_OFF_KEY_LO: rdata = offered_key[31:0];
         `FISR_OFF_KEY_HI: rdata = offered_key[63:32];
         `FISR_OFF_STATE: rdata = {27'h000_0000, key_locked, load_err, state};
         default: rdata = 32'h0000_0000;
      endcase
   end
   // bus slave: zero-wait after the hold, stalled with pready low during it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable & ~stall | psel & penable & ~pready & ~stall;
         prdata <= rdata;
         pslverr <= psel & (paddr > `FISR_OFF_STATE);
      end
   end
   // everything below restarts from constants, so a reset mid-command aborts it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_HOLD;
         hold_cnt <= 4'h0;
         load_idx <= 3'd0;
         run_cnt <= 8'h00;
         cmd_complete_flag <= 1'b0;
         cmd_complete_irq_en <= 1'b0;
         double_fault_flag <= 1'b0;
         double_fault_irq_en <= 1'b0;
         single_fault_flag <= 1'b0;
         single_fault_irq_en <= 1'b0;
         acc_err <= 1'b0;
         verify_fault_status <= 2'b00;
         security_reg <= `FISR_SEC_DEFAULT;
         program_array_protect_reg <= `FISR_PROT_DEFAULT;
         data_array_protect_reg <= `FISR_PROT_DEFAULT;
         option_reg <= `FISR_OPT_DEFAULT;
         cmd_index_reg <= 3'd0;
         cmd_code <= 8'h00;
         offered_key <= 64'h0000_0000_0000_0000;
         stored_key <= 64'h0000_0000_0000_0000;
         key_locked <= 1'b0;
         load_err <= 1'b0;
         erased_seen <= 1'b0;
         flash_rd_req <= 1'b0;
         flash_rd_addr <= 18'h0_0000;
         array_read_block <= 1'b0;
      end else begin
         // read faults: set beats a same-cycle clear
         if (wr & (paddr == `FISR_OFF_FAULT_STATUS)) begin
            if (pwdata[1])
               double_fault_flag <= 1'b0;
            if (pwdata[0])
               single_fault_flag <= 1'b0;
         end
         if (array_read_double_fault)
            double_fault_flag <= 1'b1;
         if (array_read_single_fault)
            single_fault_flag <= 1'b1;
         if (wr & ~stall & (paddr == `FISR_OFF_CONFIG))
            cmd_complete_irq_en <= pwdata[7];
         if (wr & ~stall & (paddr == `FISR_OFF_FAULT_CONFIG)) begin
            double_fault_irq_en <= pwdata[1];
            single_fault_irq_en <= pwdata[0];
         end
         if (wr & ~stall & (paddr == `FISR_OFF_STATUS) & pwdata[`FISR_STAT_ACCERR_BIT])
            acc_err <= 1'b0;
         if (wr & cmd_wr_ok & (paddr == `FISR_OFF_CMD_INDEX))
            cmd_index_reg <= pwdata[2:0];
         if (wr & cmd_wr_ok & (paddr == `FISR_OFF_CMD_WORD))
            cmd_code <= pwdata[7:0];
         if (wr & cmd_wr_ok & (paddr == `FISR_OFF_KEY_LO))
            offered_key[31:0] <= pwdata;
         if (wr & cmd_wr_ok & (paddr == `FISR_OFF_KEY_HI))
            offered_key[63:32] <= pwdata;
         case (state)
            ST_HOLD: begin
               hold_cnt <= hold_cnt + 4'h1;
               if (hold_cnt == `FISR_HOLD_CYCLES) begin
                  state <= ST_LOAD;
                  erased_seen <= flash_array_erased;
               end
            end
            ST_LOAD: begin
               flash_rd_req <= 1'b1;
               flash_rd_addr <= load_addr;
               state <= ST_WAITRD;
            end
            ST_WAITRD: begin
               if (flash_rd_valid) begin
                  flash_rd_req <= 1'b0;
                  if (flash_rd_double_fault) begin
                     verify_fault_status <= 2'b11;
                     load_err <= 1'b1;
                  end else if (flash_rd_single_fault)
                     verify_fault_status[1] <= 1'b1;
                  case (load_idx)
                     3'd0: stored_key[15:0] <= flash_rd_data;
                     3'd1: stored_key[31:16] <= flash_rd_data;
                     3'd2: stored_key[47:32] <= flash_rd_data;
                     3'd3: stored_key[63:48] <= flash_rd_data;
                     3'd4: program_array_protect_reg <= flash_rd_data[7:0];
                     3'd5: data_array_protect_reg <= flash_rd_data[7:0];
                     3'd6: option_reg <= flash_rd_data[7:0];
                     default: security_reg <= flash_rd_data[7:0];
                  endcase
                  if (load_idx == 3'd7) begin
                     state <= ST_IDLE;
                     cmd_complete_flag <= 1'b1;
                     if (load_err | flash_rd_double_fault) begin
                        program_array_protect_reg <= `FISR_PROT_DEFAULT;
                        data_array_protect_reg <= `FISR_PROT_DEFAULT;
                        option_reg <= `FISR_OPT_DEFAULT;
                        security_reg <= `FISR_SEC_DEFAULT;
                     end else if (special_mode & erased_seen)
                        security_reg <= {flash_rd_data[7:2], `FISR_SEC_UNSECURE};
                  end else begin
                     load_idx <= load_idx + 3'd1;
                     state <= ST_LOAD;
                  end
               end
            end
            ST_IDLE: begin
               if (launch) begin
                  if (allowed) begin
                     cmd_complete_flag <= 1'b0;
                     run_cnt <= 8'h00;
                     state <= ST_RUN;
                     array_read_block <= key_cmd;
                  end else
                     acc_err <= 1'b1;
               end
            end
            ST_RUN: begin
               run_cnt <= run_cnt + 8'h01;
               // a stop request does not cut the command short
               if (run_cnt == `FISR_CMD_CYCLES) begin
                  state <= ST_IDLE;
                  cmd_complete_flag <= 1'b1;
                  array_read_block <= 1'b0;
                  if (key_cmd) begin
                     // only the live state field changes; stored copies untouched
                     if (key_match)
                        security_reg[1:0] <= `FISR_SEC_UNSECURE;
                     else
                        key_locked <= 1'b1;
                  end
               end
            end
            default: state <= ST_HOLD;
         endcase
      end
   end
   // interrupts are plain levels; wait mode is deliberately not an input to them
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_irq <= 1'b0;
         error_irq <= 1'b0;
         stop_ack <= 1'b0;
         secured <= 1'b1;
         debug_cmds_enabled <= 1'b0;
      end else begin
         cmd_irq <= cmd_complete_flag & cmd_complete_irq_en;
         error_irq <= double_fault_flag & double_fault_irq_en | single_fault_flag & single_fault_irq_en;
         stop_ack <= stop_req & (state == ST_IDLE);
         secured <= (security_state_field != `FISR_SEC_UNSECURE);
         debug_cmds_enabled <= (security_state_field == `FISR_SEC_UNSECURE);
      end
   end
endmodule // fisr_ctrl

/* verif/fisr_ctrl_monitor.sv */
// port relation checks for the flash control block
`timescale 1ns/1ps
module fisr_ctrl_monitor (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [11:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire flash_rd_req,
   input wire [17:0] flash_rd_addr,
   input wire flash_rd_valid,
   input wire stop_req,
   input wire stop_ack,
   input wire secured,
   input wire debug_cmds_enabled
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence access_s; psel && penable && !pready; endsequence
   sequence answer_s; ##[1:20] pready; endsequence
   reset_hold_stall_a: assert property ($rose(presetn) |-> !pready [*5])
      else $error("apb answered during reset hold");
   access_answer_a: assert property (access_s |-> answer_s) else $error("apb access never answered");
   ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
   ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
   unmapped_error_a: assert property (pready && paddr > 12'h034 |-> pslverr) else $error("no error on unmapped");
   load_addr_a: assert property (flash_rd_req |-> flash_rd_addr[17:4] == 14'h3FF0)
      else $error("load read outside config field");
   load_hold_a: assert property (flash_rd_req && !flash_rd_valid |=> flash_rd_req && $stable(flash_rd_addr))
      else $error("load read dropped early");
   stop_cause_a: assert property (stop_ack |-> $past(stop_req)) else $error("stop ack without request");
   debug_secure_a: assert property (debug_cmds_enabled |-> !secured) else $error("debug open while secured");
endmodule // fisr_ctrl_monitor
bind fisr_ctrl fisr_ctrl_monitor i_mon (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .flash_rd_req,
   .flash_rd_addr, .flash_rd_valid, .stop_req, .stop_ack, .secured, .debug_cmds_enabled);

/* verif/fisr_flash_model.sv */
// configuration field model answering the reset load reads
`timescale 1ns/1ps
module fisr_flash_model #(
   parameter [63:0] KEYS = 64'h1357_2468_a5c3_0f96,
   parameter [7:0] PROT = 8'h5a,
   parameter [7:0] DPROT = 8'h33,
   parameter [7:0] OPT = 8'h3c,
   parameter [7:0] SEC = 8'h80,
   parameter LAT = 2
) (
   input wire pclk,
   input wire presetn,
   input wire flash_rd_req,
   input wire [17:0] flash_rd_addr,
   input wire inject_dbl,
   output reg flash_rd_valid,
   output reg [15:0] flash_rd_data,
   output reg flash_rd_single_fault,
   output reg flash_rd_double_fault
);
   reg [3:0] cnt;
   reg [15:0] word;
   always @* begin
      case (flash_rd_addr[3:0])
         4'hC: word = {PROT, PROT};
         4'hD: word = {DPROT, DPROT};
         4'hE: word = {OPT, OPT};
         4'hF: word = {SEC, SEC};
         default: word = KEYS[flash_rd_addr[2:1]*16 +: 16];
      endcase
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         flash_rd_valid <= 1'b0;
         flash_rd_data <= 16'h5a5a;
         flash_rd_single_fault <= 1'b0;
         flash_rd_double_fault <= 1'b0;
      end else begin
         flash_rd_valid <= 1'b0;
         flash_rd_double_fault <= 1'b0;
         // idle data toggles so a late sample is never a lucky match
         flash_rd_data <= ~flash_rd_data;
         if (flash_rd_req && !flash_rd_valid) begin
            cnt <= cnt + 4'h1;
            if (cnt == LAT) begin
               cnt <= 4'h0;
               flash_rd_valid <= 1'b1;
               flash_rd_data <= word;
               flash_rd_double_fault <= inject_dbl;
            end
         end
      end
   end
endmodule // fisr_flash_model

/* verif/tb_top.sv */
// self-checking bench for the flash control block
`timescale 1ns/1ps
module tb_top;
   localparam [63:0] KEYS = 64'h1357_2468_a5c3_0f96;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, inject_dbl = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, flash_rd_req, flash_rd_valid, rd_sf, rd_df, stop_ack, array_read_block;
   logic cmd_irq, error_irq, secured, debug_cmds_enabled, rerr;
   logic ar_sf = 0, ar_df = 0, special_mode = 0, stop_req = 0, wait_mode = 0, flash_array_erased = 0;
   logic [17:0] flash_rd_addr;
   logic [15:0] flash_rd_data;
   logic [63:0] q[$];
   int n_mismatch = 0, checked = 0;
   initial forever #2 pclk = ~pclk;
   fisr_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .flash_rd_req, .flash_rd_addr, .flash_rd_valid, .flash_rd_data, .flash_rd_single_fault(rd_sf),
      .flash_rd_double_fault(rd_df), .flash_array_erased, .array_read_single_fault(ar_sf),
      .array_read_double_fault(ar_df), .special_mode, .stop_req, .wait_mode, .stop_ack, .array_read_block,
      .cmd_irq, .error_irq, .secured, .debug_cmds_enabled);
   fisr_flash_model #(.KEYS(KEYS)) i_flash (.pclk, .presetn, .flash_rd_req, .flash_rd_addr, .inject_dbl,
      .flash_rd_valid, .flash_rd_data, .flash_rd_single_fault(rd_sf), .flash_rd_double_fault(rd_df));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task stop_test;
      if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
         input logic [31:0] e);
      int n;
      n = 0;
      if (!w) q.push_back({m, e});
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_mismatch++;
      r = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wait_done;
      int n;
      for (n = 0; n < 100; n++) begin
         apb(0, 12'h000, 0, 0, 0);
         if (r[7] === 1'b1) break;
      end
      if (n == 100) n_mismatch++;
   endtask
   task automatic do_reset;
      @(posedge pclk) presetn <= 0;
      repeat (4) @(posedge pclk);
      presetn <= 1;
      wait_done();
   endtask
   task automatic key(input logic [63:0] k);
      apb(1, 12'h024, 32'h0000_000C, 0, 0);
      apb(1, 12'h028, k[31:0], 0, 0);
      apb(1, 12'h02C, k[63:32], 0, 0);
      apb(1, 12'h000, 32'h0000_0080, 0, 0);
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
         if (q[0][63:32] != 0) chk(prdata & q[0][63:32], q[0][31:0]);
         void'(q.pop_front());
      end
   end
   initial begin
      #100000;
      n_mismatch++;
      stop_test();
   end
   initial begin
      void'($urandom(32'h0a42cd49));
      do_reset();
      apb(0, 12'h000, 0, 32'h0000_0083, 32'h0000_0083);
      apb(0, 12'h010, 0, 32'h0000_00ff, 32'h0000_0000);
      chk(secured, 1);
      inject_dbl <= 0;
      do_reset();
      apb(0, 12'h010, 0, 32'h0000_00ff, 32'h0000_0080);
      apb(0, 12'h014, 0, 32'h0000_00ff, 32'h0000_005a);
      apb(0, 12'h01C, 0, 32'h0000_00ff, 32'h0000_003c);
      apb(0, 12'h040, 0, 0, 0);
      chk(rerr, 1);
      wait_mode <= 1;
      apb(1, 12'h004, 32'h0000_0080, 0, 0);
      repeat (3) @(posedge pclk);
      chk(cmd_irq, 1);
      apb(1, 12'h004, 0, 0, 0);
      repeat (3) @(posedge pclk);
      chk(cmd_irq, 0);
      apb(1, 12'h00C, 32'h0000_0003, 0, 0);
      for (int i = 0; i < 2; i++) begin
         {ar_df, ar_sf} <= 2'b01 << i;
         @(posedge pclk) {ar_df, ar_sf} <= 2'b00;
         repeat (3) @(posedge pclk);
         chk(error_irq, 1);
         apb(0, 12'h008, 0, 32'h0000_0003, 32'h1 << i);
         apb(1, 12'h008, 32'h1 << i, 0, 0);
         repeat (3) @(posedge pclk);
         chk(error_irq, 0);
      end
      stop_req <= 1;
      key(KEYS ^ {32'h0, $urandom | 32'h1});
      repeat (2) @(posedge pclk);
      chk(array_read_block, 1);
      chk(stop_ack, 0);
      wait_done();
      repeat (3) @(posedge pclk);
      chk(stop_ack, 1);
      key(KEYS);
      wait_done();
      chk(secured, 1);
      stop_req <= 0;
      do_reset();
      key(KEYS);
      wait_done();
      chk(secured, 0);
      // live state field reads unsecure, the loaded upper bits stay as stored
      apb(0, 12'h010, 0, 32'h0000_00ff, 32'h0000_0082);
      apb(0, 12'h014, 0, 32'h0000_00ff, 32'h0000_005a);
      key(KEYS);
      repeat (4) @(posedge pclk);
      do_reset();
      chk(secured, 1);
      special_mode <= 1;
      flash_array_erased <= 1;
      do_reset();
      chk(secured, 0);
      chk(debug_cmds_enabled, 1);
      stop_test();
   end
endmodule // tb_top
